// >>> ebra_arbiter.sv
// What this block does
// - sample request one state before cycle end
// - late request: run next cycle, then release
// - release after cycle holding the request
// - never release inside one logical bus cycle
// - atomic test-and-set read and write stay together
// - refresh and following cycle are one period
// - grant asserted 1.5 states after last cycle; code rounds up to 2 clock cycles
// - latency: longest locked period plus 4.5 states
// - priority: outside, refresh, dma, then cpu
// - refresh while released negates grant, waits request drop
// - refresh during dma burst halts the burst
`timescale 1ns/1ps
`include "ebra_regs.svh"

module ebra_arbiter
(
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // outside master pins
  input wire logic bus_request_in_n_i,
  output logic bus_grant_n_o,
  // internal requesters
  input wire logic refresh_req_i,
  input wire logic dma_req_i,
  input wire logic dma_burst_i,
  input wire logic cpu_req_i,
  // bus cycle sequencer
  input wire logic cyc_pre_end_i,
  input wire logic cyc_end_i,
  input wire logic cyc_lock_i,
  // ownership
  output logic bus_released_o,
  output logic owner_cpu_o,
  output logic owner_dma_o,
  output logic owner_refresh_o,
  output logic dma_halt_o
);

  localparam logic [`EBRA_CNT_W-1:0] GRANT_LOAD = `EBRA_CNT_W'(`EBRA_GRANT_DELAY_CYC - 1);

  ebra_arb_if arb_if ();

  ebra_prio u_prio
  (
    .arb_if(arb_if.prio)
  );

  assign arb_if.refresh_req = refresh_req_i;
  assign arb_if.dma_req = dma_req_i;
  assign arb_if.cpu_req = cpu_req_i;

  ebra_pkg::ebra_state_type state;
  ebra_pkg::ebra_state_type next_state;
  ebra_pkg::ebra_owner_type owner;
  ebra_pkg::ebra_owner_type next_owner;
  logic req_meta;
  logic req_sync;
  logic rel_armed;
  logic [`EBRA_CNT_W-1:0] grant_cnt;

  // pin crosses in from the outside master: two flops, meta read only by req_sync
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
    end
    else if (ce_i)
    begin
      req_meta <= ~bus_request_in_n_i;
      req_sync <= req_meta;
    end
  end

  wire logic st_own = (state == ebra_pkg::EBRA_OWN);
  wire logic st_delay = (state == ebra_pkg::EBRA_DELAY);
  wire logic st_released = (state == ebra_pkg::EBRA_RELEASED);
  wire logic st_reclaim = (state == ebra_pkg::EBRA_RECLAIM);
  wire logic owner_is_refresh = (owner == ebra_pkg::EBRA_OWNER_REFRESH);
  wire logic to_own = (next_state == ebra_pkg::EBRA_OWN);
  wire logic owner_load = (st_own && cyc_end_i) || (!st_own && to_own);
  // outputs follow the owner picked at this edge, not the one it replaces
  assign next_owner = owner_load ? arb_if.pick : owner;
  // a refresh cycle always chains into the cycle after it
  wire logic cycle_locked = cyc_lock_i | owner_is_refresh;
  // release only at an unlocked boundary after a request sampled in this cycle
  wire logic release_go = st_own & cyc_end_i & rel_armed & ~cycle_locked;
  wire logic grant_done = st_delay & (grant_cnt == '0);
  wire logic next_grant_n = ~(next_state == ebra_pkg::EBRA_RELEASED);

  // request only counts at the sample point; a late one waits for the next cycle's
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      rel_armed <= 1'b0;
    else if (ce_i && cyc_pre_end_i && st_own)
      rel_armed <= req_sync;
    else if (ce_i && cyc_end_i)
      rel_armed <= 1'b0;
  end

  always_comb
  begin
    next_state = state;
    case (state)
      ebra_pkg::EBRA_OWN:
        if (release_go)
          next_state = ebra_pkg::EBRA_DELAY;
      ebra_pkg::EBRA_DELAY:
        if (grant_done)
          next_state = ebra_pkg::EBRA_RELEASED;
      ebra_pkg::EBRA_RELEASED:
        if (!req_sync)
          next_state = ebra_pkg::EBRA_OWN;
        else if (refresh_req_i)
          next_state = ebra_pkg::EBRA_RECLAIM;
      ebra_pkg::EBRA_RECLAIM:
        // bus stays out until the outside master lets go
        if (!req_sync)
          next_state = ebra_pkg::EBRA_OWN;
      default:
        next_state = ebra_pkg::EBRA_OWN;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      state <= ebra_pkg::EBRA_OWN;
    else if (ce_i)
      state <= next_state;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      grant_cnt <= '0;
    else if (ce_i && release_go)
      grant_cnt <= GRANT_LOAD;
    else if (ce_i && st_delay && grant_cnt != '0)
      grant_cnt <= grant_cnt - `EBRA_CNT_W'(1);
  end

  // owner of the next internal cycle is chosen at each boundary and whenever the bus comes back to EBRA_OWN
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      owner <= ebra_pkg::EBRA_OWNER_CPU;
    else if (ce_i)
      owner <= next_owner;
  end

  // outputs straight from flops
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      bus_grant_n_o <= `EBRA_GRANT_N_RST;
      bus_released_o <= 1'b0;
      owner_cpu_o <= 1'b0;
      owner_dma_o <= 1'b0;
      owner_refresh_o <= 1'b0;
      dma_halt_o <= 1'b0;
    end
    else if (ce_i)
    begin
      bus_grant_n_o <= next_grant_n;
      // pins stay released through reclaim: the outside master may still run a cycle
      bus_released_o <= (next_state == ebra_pkg::EBRA_RELEASED)
        || (next_state == ebra_pkg::EBRA_RECLAIM);
      owner_cpu_o <= to_own && (next_owner == ebra_pkg::EBRA_OWNER_CPU);
      owner_dma_o <= to_own && (next_owner == ebra_pkg::EBRA_OWNER_DMA);
      owner_refresh_o <= to_own && (next_owner == ebra_pkg::EBRA_OWNER_REFRESH);
      dma_halt_o <= refresh_req_i & dma_burst_i;
    end
  end

  // timing checks assume ce_i held high
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_sample_point_only: assert property (
    (ce_i && !cyc_pre_end_i && !cyc_end_i) |=> $stable(rel_armed))
    else $error("release decision changed outside the sample point");

  a_late_request_waits: assert property (
    (ce_i && st_own && cyc_end_i && !rel_armed) |=> st_own)
    else $error("bus released without a sampled request");

  a_locked_cycle_kept: assert property (
    (ce_i && st_own && cyc_end_i && cyc_lock_i) |=> st_own)
    else $error("bus released inside a locked cycle");

  a_atomic_pair_kept: assert property (
    (ce_i && st_own && cyc_end_i && cyc_lock_i && rel_armed) |=> !st_delay)
    else $error("atomic test-and-set pair broken by release");

  a_refresh_pair_kept: assert property (
    (ce_i && st_own && cyc_end_i && owner_is_refresh) |=> st_own)
    else $error("bus released right after a refresh cycle");

  a_grant_delay_exact: assert property (
    (ce_i && release_go) |=> bus_grant_n_o ##1 bus_grant_n_o ##1 !bus_grant_n_o)
    else $error("grant not asserted two cycles after cycle end");

  a_release_latency: assert property (
    (ce_i && st_own && cyc_pre_end_i && req_sync)
    ##1 (ce_i && cyc_end_i && !cycle_locked)
    |=> ##[1:3] (!bus_grant_n_o && bus_released_o))
    else $error("release latency beyond margin");

  a_refresh_negates: assert property (
    (ce_i && st_released && req_sync && refresh_req_i) |=> (bus_grant_n_o && bus_released_o))
    else $error("grant kept while refresh pending");

  a_reclaim_holds: assert property (
    (ce_i && st_reclaim && req_sync) |=> (st_reclaim && bus_released_o))
    else $error("bus taken back before request dropped");

  a_priority_refresh: assert property (
    (ce_i && st_own && cyc_end_i && refresh_req_i && !release_go) |=> owner_refresh_o)
    else $error("refresh lost priority to dma or cpu");

  a_dma_burst_halt: assert property (
    (ce_i && refresh_req_i && dma_burst_i) |=> dma_halt_o)
    else $error("dma burst not halted for refresh");

  a_grant_until_drop: assert property (
    (ce_i && st_released && !req_sync) |=> (st_own && bus_grant_n_o && !bus_released_o))
    else $error("bus not resumed after request dropped");

endmodule : ebra_arbiter

// >>> ebra_regs.svh
`ifndef EBRA_REGS_SVH
`define EBRA_REGS_SVH

// grant follows the end of the last internal cycle by 1.5 states
`define EBRA_GRANT_DELAY_HALF_STATES 3
// least time, so the half state rounds up to whole clock cycles
`define EBRA_GRANT_DELAY_CYC ((`EBRA_GRANT_DELAY_HALF_STATES + 1) / 2)
// release latency margin beyond the longest unbreakable period, 4.5 states
`define EBRA_LATENCY_MARGIN_HALF_STATES 9
`define EBRA_LATENCY_MARGIN_CYC ((`EBRA_LATENCY_MARGIN_HALF_STATES + 1) / 2)
// width of the grant delay counter
`define EBRA_CNT_W 2
// reset level of the active-low grant pin: not granted
`define EBRA_GRANT_N_RST 1'b1

`endif

// >>> ebra_pkg.sv
package ebra_pkg;

  // release sequencer states, one-hot
  typedef enum logic [3:0] {
    EBRA_OWN = 4'h1,
    EBRA_DELAY = 4'h2,
    EBRA_RELEASED = 4'h4,
    EBRA_RECLAIM = 4'h8
  } ebra_state_type;

  // owner of the next internal bus cycle, one-hot
  typedef enum logic [2:0] {
    EBRA_OWNER_CPU = 3'h1,
    EBRA_OWNER_DMA = 3'h2,
    EBRA_OWNER_REFRESH = 3'h4
  } ebra_owner_type;

endpackage : ebra_pkg

// >>> ebra_arb_if.sv
`timescale 1ns/1ps

interface ebra_arb_if;
  logic refresh_req;
  logic dma_req;
  logic cpu_req;
  ebra_pkg::ebra_owner_type pick;

  modport arb
  (
    output refresh_req,
    output dma_req,
    output cpu_req,
    input pick
  );

  modport prio
  (
    input refresh_req,
    input dma_req,
    input cpu_req,
    output pick
  );
endinterface : ebra_arb_if

// >>> ebra_prio.sv
`timescale 1ns/1ps

module ebra_prio
(
  ebra_arb_if.prio arb_if
);

  // the outside master is handled by the release sequencer; inside: refresh > dma > cpu
  function automatic ebra_pkg::ebra_owner_type ebra_pick
  (
    input logic refresh_req,
    input logic dma_req
  );
    if (refresh_req)
      return ebra_pkg::EBRA_OWNER_REFRESH;
    else if (dma_req)
      return ebra_pkg::EBRA_OWNER_DMA;
    else
      return ebra_pkg::EBRA_OWNER_CPU;
  endfunction : ebra_pick

  // cpu is the default owner, so cpu_req needs no term of its own
  assign arb_if.pick = ebra_pick(arb_if.refresh_req, arb_if.dma_req);

endmodule : ebra_prio

// >>> ebra_master_model.sv
`timescale 1ns/1ps

module ebra_master_model
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // bench control
  input wire logic want_i,
  // device pins
  input wire logic bus_grant_n_i,
  output logic bus_request_in_n_o
);
  logic grant_q;
  logic had_grant;

  // one capture flop, fanned out, so a grant spike cannot split
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      grant_q <= 1'b0;
      had_grant <= 1'b0;
      bus_request_in_n_o <= 1'b1;
    end
    else
    begin
      grant_q <= !bus_grant_n_i;
      had_grant <= want_i & (had_grant | grant_q);
      bus_request_in_n_o <= !(want_i & !(had_grant & !grant_q));
    end
  end
endmodule : ebra_master_model

// >>> testbench.sv
`timescale 1ns/1ps
`include "ebra_regs.svh"

module testbench;
  logic sys_clk_i, sys_rst_i, want, req_n, grant_n, refresh, dma, burst;
  logic pre_end, cyc_end, lock, rel, o_cpu, o_dma, o_ref, halt;
  int fail_count, num_checks;

  ebra_arbiter dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
    .bus_request_in_n_i(req_n), .bus_grant_n_o(grant_n), .refresh_req_i(refresh),
    .dma_req_i(dma), .dma_burst_i(burst), .cpu_req_i(1'b1), .cyc_pre_end_i(pre_end),
    .cyc_end_i(cyc_end), .cyc_lock_i(lock), .bus_released_o(rel), .owner_cpu_o(o_cpu),
    .owner_dma_o(o_dma), .owner_refresh_o(o_ref), .dma_halt_o(halt));
  ebra_master_model partner (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .want_i(want), .bus_grant_n_i(grant_n), .bus_request_in_n_o(req_n));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  task results;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task chk(string name, logic exp, logic got);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask : chk

  task step(int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : step

  // one logical cycle: pre-end state, then last state
  task cyc(logic lk);
    pre_end = 1'b1;
    step(1);
    pre_end = 1'b0;
    cyc_end = 1'b1;
    lock = lk;
    step(1);
    cyc_end = 1'b0;
    lock = 1'b0;
  endtask : cyc

  // counts rising edges until grant reaches lvl
  task wait_grant(logic lvl, output int n);
    n = 0;
    while (grant_n !== lvl && n < 20)
    begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (n >= 20)
    begin
      chk("grant_wait", lvl, grant_n);
      results();
    end
  endtask : wait_grant

  task wait_back;
    int k;
    k = 0;
    while (rel !== 1'b0 && k < 20)
    begin
      step(1);
      k++;
    end
    chk("released_back", 1'b0, rel);
  endtask : wait_back

  task t_release(logic lk);
    int n;
    want = 1'b1;
    step(3);
    if (lk)
    begin
      cyc(1'b1);
      step(3);
      chk("grant_locked", 1'b1, grant_n);
    end
    cyc(1'b0);
    wait_grant(1'b0, n);
    chk("grant_delay", 1'b1, n == `EBRA_GRANT_DELAY_CYC);
    chk("released", 1'b1, rel);
    chk("owner_cpu_off", 1'b0, o_cpu);
    step(4);
    chk("grant_held", 1'b0, grant_n);
    want = 1'b0;
    wait_back();
    step(1);
    chk("owner_cpu_back", 1'b1, o_cpu);
  endtask : t_release

  // request syncs between the sample point and the end of cycle a
  task t_late;
    int n;
    want = 1'b1;
    step(2);
    cyc(1'b0);
    cyc(1'b0);
    wait_grant(1'b0, n);
    chk("grant_after_b", 1'b1, n == `EBRA_GRANT_DELAY_CYC);
    step(1);
    want = 1'b0;
    wait_back();
    step(1);
  endtask : t_late

  // request armed during a refresh cycle waits for the cycle after it
  task t_refresh_pair;
    int n;
    refresh = 1'b1;
    cyc(1'b0);
    refresh = 1'b0;
    want = 1'b1;
    step(3);
    cyc(1'b0);
    step(3);
    chk("refresh_pair_held", 1'b0, rel);
    cyc(1'b0);
    wait_grant(1'b0, n);
    chk("grant_after_pair", 1'b1, n == `EBRA_GRANT_DELAY_CYC);
    step(1);
    want = 1'b0;
    wait_back();
    step(1);
  endtask : t_refresh_pair

  task t_refresh;
    int n;
    want = 1'b1;
    step(3);
    cyc(1'b0);
    wait_grant(1'b0, n);
    step(1);
    refresh = 1'b1;
    step(1);
    chk("grant_negated", 1'b1, grant_n);
    chk("still_released", 1'b1, rel);
    wait_back();
    chk("owner_refresh_back", 1'b1, o_ref);
    refresh = 1'b0;
    want = 1'b0;
    cyc(1'b0);
    step(1);
    chk("owner_cpu_after", 1'b1, o_cpu);
  endtask : t_refresh

  task t_dma;
    dma = 1'b1;
    burst = 1'b1;
    refresh = 1'b1;
    step(1);
    chk("dma_halt", 1'b1, halt);
    cyc(1'b0);
    step(1);
    chk("owner_refresh", 1'b1, o_ref);
    refresh = 1'b0;
    burst = 1'b0;
    cyc(1'b0);
    step(1);
    chk("owner_dma", 1'b1, o_dma);
    dma = 1'b0;
  endtask : t_dma

  initial
  begin
    fail_count = 0;
    num_checks = 0;
    {want, refresh, dma, burst, pre_end, cyc_end, lock} = 7'h00;
    sys_rst_i = 1'b1;
    step(5);
    sys_rst_i = 1'b0;
    chk("grant_reset", 1'b1, grant_n);
    chk("released_reset", 1'b0, rel);
    // refresh kept idle while requesting
    t_release(1'b0);
    t_release(1'b1);
    t_late();
    t_refresh_pair();
    t_refresh();
    t_dma();
    results();
  end
endmodule : testbench
